//--- rtl/tms_defs.svh
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH

// strap capture delay after reset release, in nanoseconds
`define TMS_CAPTURE_DELAY_NS 1500
`define TMS_CLK_PERIOD_NS    8
// cycles: 1500 ns / 8 ns rounds down to 187
`define TMS_CAPTURE_CYCLES   (`TMS_CAPTURE_DELAY_NS / `TMS_CLK_PERIOD_NS)
`define TMS_PIN_COUNT        8
`define TMS_CNT_W            8
`define TMS_CODE_RESET       8'h00
`define TMS_CNT_ZERO         8'h00
`define TMS_CNT_ONE          8'h01

`endif

//--- rtl/tms_pkg.sv
package tms_pkg;
  `include "tms_defs.svh"

  typedef enum logic [1:0] {
    TMS_HELD,
    TMS_WAIT,
    TMS_DRIVE
  } tms_state_t;

  // one bundle for the drive value and the enable of every test pin
  typedef struct packed {
    logic [`TMS_PIN_COUNT-1:0] out;
    logic [`TMS_PIN_COUNT-1:0] oe;
  } tms_pin_drive_t;
endpackage : tms_pkg

//--- rtl/tms_strap_sampler.sv
`timescale 1ns/10ps
// What this block does
// [R1] pins undriven while power-on reset held low
// [R2] capture pin levels about 1.5 us after release
// [R3] after capture, drive each pin as output
// [R4] pin n feeds select code bit n
// [R5] weak pulldown makes open pin read low
// [R6] board must not pull pins high
// [R7] board leaves test pins unconnected normally
// [R8] start configuration on reset low-to-high edge
// [R9] select code held until next reset
`include "tms_defs.svh"
module tms_strap_sampler
  import tms_pkg::*;
#(
  parameter int unsigned CAPTURE_CYCLES = `TMS_CAPTURE_CYCLES
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  input  wire logic                      i_power_on_reset_n,
  input  wire logic [`TMS_PIN_COUNT-1:0] i_test_point,
  input  wire logic [`TMS_PIN_COUNT-1:0] i_test_out_data,
  output logic      [`TMS_PIN_COUNT-1:0] o_test_point,
  output logic      [`TMS_PIN_COUNT-1:0] o_test_point_oe,
  output logic      [`TMS_PIN_COUNT-1:0] o_test_point_pulldown,
  output logic      [`TMS_PIN_COUNT-1:0] o_test_mode_select_code,
  output logic                           o_capture_done
);

  localparam logic [`TMS_CNT_W-1:0] CNT_LAST = CAPTURE_CYCLES[`TMS_CNT_W-1:0];

  // pins and reset come from off chip: two stages before any logic looks
  logic [`TMS_PIN_COUNT-1:0] pin_meta_q, pin_sync_q;
  logic [`TMS_PIN_COUNT-1:0] pin_meta_d, pin_sync_d;
  logic                      rst_meta_q, rst_sync_q, rst_prev_q;
  logic                      rst_meta_d, rst_sync_d, rst_prev_d;

  // next values of the output flops; every output leaves straight from a flop
  logic [`TMS_PIN_COUNT-1:0] point_d;
  logic [`TMS_PIN_COUNT-1:0] point_oe_d;
  logic [`TMS_PIN_COUNT-1:0] pulldown_d;
  logic [`TMS_PIN_COUNT-1:0] select_code_d;
  logic                      capture_done_d;

  tms_state_t                state_q, state_d;
  logic [`TMS_CNT_W-1:0]     cnt_q, cnt_d;
  logic [`TMS_PIN_COUNT-1:0] code_q, code_d;
  tms_pin_drive_t            drv_q, drv_d;
  logic                      done_q, done_d;

  always_comb begin
    pin_meta_d = i_test_point;
    pin_sync_d = pin_meta_q;
    rst_meta_d = i_power_on_reset_n;
    rst_sync_d = rst_meta_q;
    rst_prev_d = rst_sync_q;
  end

  // pin stages carry no reset: only the second stage feeds the capture logic
  always_ff @(posedge i_mclk) begin
    pin_meta_q <= pin_meta_d;
    pin_sync_q <= pin_sync_d;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
      rst_prev_q <= rst_prev_d;
    end
  end

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    code_d       = code_q;
    drv_d.out    = i_test_out_data;
    drv_d.oe     = drv_q.oe;
    done_d       = done_q;
    case (state_q)
      TMS_HELD: begin
        drv_d.oe = '0;
        if (rst_sync_q && !rst_prev_q) begin // see [R8]
          state_d = TMS_WAIT;
          cnt_d   = `TMS_CNT_ONE;
        end
      end
      TMS_WAIT: begin
        if (cnt_q >= CNT_LAST) begin // see [R2]
          code_d   = pin_sync_q;       // see [R4]
          drv_d.oe = '1;               // see [R3]
          done_d   = 1'b1;
          state_d  = TMS_DRIVE;
        end else begin
          cnt_d = cnt_q + `TMS_CNT_ONE;
        end
      end
      TMS_DRIVE: begin
        // code frozen here; only a new reset can reopen capture
        drv_d.oe = '1; // see [R9]
      end
      default: begin
        state_d = TMS_HELD;
      end
    endcase
    // reset low overrides state, count, enables, done and code: pins float, code cleared for next capture
    if (!rst_sync_q) begin // see [R1]
      state_d  = TMS_HELD;
      cnt_d    = `TMS_CNT_ZERO;
      drv_d.oe = '0;
      done_d   = 1'b0;
      code_d   = `TMS_CODE_RESET;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= TMS_HELD;
      cnt_q   <= `TMS_CNT_ZERO;
      code_q  <= `TMS_CODE_RESET;
      drv_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      code_q  <= code_d;
      drv_q   <= drv_d;
      done_q  <= done_d;
    end
  end

  always_comb begin
    point_d        = drv_q.out;
    point_oe_d     = drv_q.oe;
    pulldown_d     = '1; // see [R5]
    select_code_d  = code_q;
    capture_done_d = done_q;
  end

  // pulldown stays on even while driving: it is too weak to fight the driver
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_test_point            <= '0;
      o_test_point_oe         <= '0;
      o_test_point_pulldown   <= '1;
      o_test_mode_select_code <= `TMS_CODE_RESET;
      o_capture_done          <= 1'b0;
    end else begin
      o_test_point            <= point_d;
      o_test_point_oe         <= point_oe_d;
      o_test_point_pulldown   <= pulldown_d;
      o_test_mode_select_code <= select_code_d;
      o_capture_done          <= capture_done_d;
    end
  end

endmodule : tms_strap_sampler

//--- test/tms_board_model.sv
`timescale 1ns/10ps
module tms_board_model (
  input  wire logic [7:0] i_oe, i_out, i_strap,
  output logic      [7:0] o_level
);
  // open pins settle to the weak pulldown; a pullup is fitted only where a test asks
  always_comb for (int n = 0; n < 8; n++) o_level[n] = i_oe[n] ? i_out[n] : i_strap[n];
endmodule : tms_board_model

//--- test/tms_strap_sampler_bench.sv
`timescale 1ns/10ps
module tms_strap_sampler_bench;
  import tms_pkg::*;
  logic       i_mclk = 0, i_rst = 1, por_n = 0, done;
  logic [7:0] strap = 8'h00, data = 8'h00, lvl, q, oe, pd, code;
  int         error_cnt = 0, checked = 0, exp, t, r = 9;
  always #4 i_mclk = ~i_mclk;
  function automatic int lfsr(int v); return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction : lfsr
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  tms_strap_sampler #(.CAPTURE_CYCLES(4)) uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_power_on_reset_n(por_n),
    .i_test_point(lvl), .i_test_out_data(data), .o_test_point(q), .o_test_point_oe(oe),
    .o_test_point_pulldown(pd), .o_test_mode_select_code(code), .o_capture_done(done));
  tms_board_model brd (.i_oe(oe), .i_out(q), .i_strap(strap), .o_level(lvl));
  initial begin
    #10000 error_cnt++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 0;
    for (int k = 0; k < 6; k++) begin
      repeat (8) @(posedge i_mclk);
      #1 chk("oe_hold", oe, 8'h00);
      @(posedge i_mclk);
      r = lfsr(r);
      exp = k ? r : 0;
      strap <= exp[7:0];
      data <= ~exp[7:0];
      por_n <= 1;
      #1 t = 0;
      while (done !== 1'b1 && t++ < 40) #8;
      chk("done", {7'h00, done}, 8'h01);
      chk("code", code, exp[7:0]);
      chk("oe", oe, 8'hff);
      chk("pulldown", pd, 8'hff);
      #16 chk("pin_out", q, ~exp[7:0]);
      @(posedge i_mclk);
      strap <= ~exp[7:0];
      repeat (8) @(posedge i_mclk);
      #1 chk("code_hold", code, exp[7:0]);
      @(posedge i_mclk);
      por_n <= 0;
    end
    // mid-run reset with power-on reset already high: counts as a fresh release
    @(posedge i_mclk);
    i_rst <= 1;
    por_n <= 1;
    strap <= 8'h5a;
    repeat (2) @(posedge i_mclk);
    i_rst <= 0;
    #1 chk("oe_rst", oe, 8'h00);
    t = 0;
    while (done !== 1'b1 && t++ < 40) #8;
    chk("code_rst", code, 8'h5a);
    conclude();
  end
endmodule : tms_strap_sampler_bench

//--- test/tms_strap_sampler_properties.sv
`timescale 1ns/10ps
module tms_chk
  import tms_pkg::*;
#(parameter int unsigned CAPTURE_CYCLES = 4) (
  input wire logic       i_mclk, i_rst, i_power_on_reset_n, o_capture_done,
  input wire logic [7:0] i_test_point, o_test_point_oe, o_test_point_pulldown, o_test_mode_select_code
);
  localparam int LO = CAPTURE_CYCLES + 3;
  localparam int HI = CAPTURE_CYCLES + 6;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_release; $rose(i_power_on_reset_n); endsequence
  sequence s_done; $rose(o_capture_done); endsequence
  AST_HIZ: assert property (!i_power_on_reset_n [*6] |-> o_test_point_oe == 8'h00)
    else $error("pins driven during reset");
  AST_DELAY: assert property (s_release |-> ##[LO:HI] s_done)
    else $error("capture late");
  AST_DRIVE: assert property (s_done |-> o_test_point_oe == 8'hff)
    else $error("pins not driven after capture");
  AST_CODE: assert property (s_done |-> o_test_mode_select_code == $past(i_test_point, 4))
    else $error("code differs from pins");
  AST_PD: assert property (o_test_point_pulldown == 8'hff)
    else $error("pulldown off");
  AST_HOLD: assert property (o_capture_done && $past(o_capture_done) |-> $stable(o_test_mode_select_code))
    else $error("code changed after capture");
endmodule : tms_chk
bind tms_strap_sampler tms_chk #(.CAPTURE_CYCLES(CAPTURE_CYCLES)) chk (.*);
